// *** sbp_side_band_port.sv ***
// module: side-band serial output enable port of a clock fanout buffer
//
// Overview of operation
// - three-wire port plus optional cascade output
// - shift clock up to 25 MHz; 50 MHz sampling here resolves a 160 ns clock, not 25 MHz
// - port works before power good asserts
// - strap high turns enable pins into port
// - out13 pin: enable low, or load strobe
// - strap caught at power-up, held static
// - strap low: port has no effect
// - shift register, readback copy, mask register
// - bit one enables, zero disables output
// - all shift bits reset to one
// - shifting uses only the shift clock
// - disabled port hands control to bus/pins
// - strobe high, sample data on rising edges
// - strobe falling edge loads control register
// - mask resets zero, one forces enabled
// - strobe low ignores clock and data
`timescale 1ns/1ps
`default_nettype none
module sbp_side_band_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // strap and power good
  input wire logic side_port_strap,
  input wire logic power_good,
  // serial port pins
  input wire logic serial_pattern_in,
  input wire logic pattern_shift_clock,
  input wire logic out13_enable_or_load_pin,
  output logic serial_pattern_out,
  // per-output enable pins, active low
  input wire logic [19:0] output_enable_pin_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // final per-output enables
  output logic [19:0] clk_out_enable
);
  localparam int N = sbp_pkg::NUM_OUT;

  ////////////////////////////////////////////////////////////////////////
  // three-stage pin synchronisers; stage 1 feeds only stage 2
  logic [2:0] sclk_s;
  logic [2:0] sdin_s;
  logic [2:0] load_s;
  logic [N-1:0] oen_s1;
  logic [N-1:0] oen_s2;
  logic [N-1:0] oen_s3;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sclk_s <= 3'h0;
      sdin_s <= 3'h0;
      load_s <= 3'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], pattern_shift_clock};
      sdin_s <= {sdin_s[1:0], serial_pattern_in};
      load_s <= {load_s[1:0], out13_enable_or_load_pin};
    end
  end

  // enable pins pass the same chain; reset to enabled-pin level
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oen_s1 <= '0;
      oen_s2 <= '0;
      oen_s3 <= '0;
    end else begin
      oen_s1 <= output_enable_pin_n;
      oen_s2 <= oen_s1;
      oen_s3 <= oen_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // filtered levels: change counts once stages two and three agree
  logic sclk_lvl_q;
  logic load_lvl_q;
  logic sclk_rise;
  logic load_fall;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sclk_lvl_q <= 1'b0;
      load_lvl_q <= 1'b0;
    end else begin
      if (sclk_s[1] == sclk_s[2]) begin
        sclk_lvl_q <= sclk_s[2];
      end
      if (load_s[1] == load_s[2]) begin
        load_lvl_q <= load_s[2];
      end
    end
  end

  assign sclk_rise = (sclk_s[1] == sclk_s[2]) && sclk_s[2] && !sclk_lvl_q;
  assign load_fall = (load_s[1] == load_s[2]) && !load_s[2] && load_lvl_q;

  ////////////////////////////////////////////////////////////////////////
  // strap capture after reset release; stays fixed until next reset
  logic strap_q;
  logic strap_done_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      strap_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_q <= side_port_strap;
      strap_done_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shift register, clocked only by detected shift clock edges
  logic [N-1:0] shift_q;
  logic port_on;

  // port pins live only when strapped
  assign port_on = strap_q && strap_done_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shift_q <= sbp_pkg::SHIFT_RST;
    end else if (port_on && load_lvl_q && sclk_rise) begin
      shift_q <= {shift_q[N-2:0], sdin_s[2]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      serial_pattern_out <= 1'b1;
    end else begin
      serial_pattern_out <= port_on ? shift_q[N-1] : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // loaded patterns queue through the fifo to the control stage
  sbp_fifo_if #(.W(N)) load_if ();
  sbp_fifo_if #(.W(N)) ctrl_if ();
  logic fifo_full;
  logic fifo_empty;

  assign load_if.valid = port_on && load_fall;
  assign load_if.data = shift_q;
  // drained each cycle; stalls only when strap disables the port
  assign ctrl_if.ready = port_on;

  sbp_fifo #(
    .W(N),
    .DEPTH(sbp_pkg::FIFO_DEPTH),
    .AW(sbp_pkg::FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .wr(load_if),
    .rd(ctrl_if),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  ////////////////////////////////////////////////////////////////////////
  // output control register and readback copy
  logic [N-1:0] ctrl_q;
  logic [N-1:0] shadow_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= sbp_pkg::SHIFT_RST;
    end else if (ctrl_if.valid && ctrl_if.ready) begin
      ctrl_q <= ctrl_if.data;
    end
  end

  // readback updates on strobe falling edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shadow_q <= sbp_pkg::SHIFT_RST;
    end else if (port_on && load_fall) begin
      shadow_q <= shift_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers: mask and bus enable bits
  logic [N-1:0] mask_q;
  logic [N-1:0] busen_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mask_q <= sbp_pkg::MASK_RST;
    end else if (reg_wr && reg_addr == sbp_pkg::REG_MASK_OFS) begin
      mask_q <= reg_wdata[N-1:0];
    end
  end

  // bus enable bits, written only once power good is up
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busen_q <= sbp_pkg::BUSEN_RST;
    end else if (reg_wr && power_good &&
                 reg_addr == sbp_pkg::REG_CTRL_OFS) begin
      busen_q <= reg_wdata[N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable combination: bus AND pin AND port indication
  logic [N-1:0] port_ind;
  logic [N-1:0] pin_en;
  logic [N-1:0] final_en;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_out
      assign port_ind[gi] = !port_on || mask_q[gi] || ctrl_q[gi];
      if (gi == sbp_pkg::OUT13_IDX) begin : g_out13
        // pin is enable when strap low
        assign pin_en[gi] = port_on ? 1'b1 : !load_s[2];
      end else begin : g_plain
        assign pin_en[gi] = !oen_s3[gi];
      end
      assign final_en[gi] = port_ind[gi] && pin_en[gi] && busen_q[gi];
    end
  endgenerate

  // registered outputs
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clk_out_enable <= '0;
    end else begin
      clk_out_enable <= final_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe; unmapped reads return zero
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      sbp_pkg::REG_CTRL_OFS: rd_mux[N-1:0] = busen_q;
      sbp_pkg::REG_MASK_OFS: rd_mux[N-1:0] = mask_q;
      sbp_pkg::REG_SHADOW_OFS: rd_mux[N-1:0] = shadow_q;
      sbp_pkg::REG_ACTIVE_OFS: rd_mux[N-1:0] = ctrl_q;
      sbp_pkg::REG_STATUS_OFS: begin
        rd_mux[sbp_pkg::STAT_STRAP_BIT] = strap_q;
        rd_mux[sbp_pkg::STAT_PGOOD_BIT] = power_good;
        rd_mux[sbp_pkg::STAT_FULL_BIT] = fifo_full;
        rd_mux[sbp_pkg::STAT_EMPTY_BIT] = fifo_empty;
      end
      sbp_pkg::REG_LINEEN_OFS: rd_mux[N-1:0] = final_en;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // shift clock limit is the far side's duty; three-stage sampling
  // at 50 MHz resolves a 160 ns link clock, not a full 25 MHz one
endmodule
`default_nettype wire

// *** sbp_pkg.sv ***
// package: constants for the side-band enable port
package sbp_pkg;
  // output count equals shift register length
  localparam int NUM_OUT = 20;
  localparam int OUT13_IDX = 13;
  // fifo between the shift register and the control stage
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
  // register offsets of the plain register port
  localparam logic [3:0] REG_CTRL_OFS = 4'h0;
  localparam logic [3:0] REG_MASK_OFS = 4'h1;
  localparam logic [3:0] REG_SHADOW_OFS = 4'h2;
  localparam logic [3:0] REG_ACTIVE_OFS = 4'h3;
  localparam logic [3:0] REG_STATUS_OFS = 4'h4;
  localparam logic [3:0] REG_LINEEN_OFS = 4'h5;
  // field positions
  localparam int STAT_STRAP_BIT = 0;
  localparam int STAT_PGOOD_BIT = 1;
  localparam int STAT_FULL_BIT = 2;
  localparam int STAT_EMPTY_BIT = 3;
  // reset values
  localparam logic [19:0] SHIFT_RST = 20'hf_ffff;
  localparam logic [19:0] MASK_RST = 20'h0_0000;
  localparam logic [19:0] BUSEN_RST = 20'hf_ffff;
  // timing: fastest shift clock allowed and its least half period
  localparam int SHIFT_CLK_MAX_MHZ = 25;
  localparam int REF_CLK_MHZ = 50;
  localparam int SHIFT_HALF_CYC =
    (REF_CLK_MHZ + 2 * SHIFT_CLK_MAX_MHZ - 1) / (2 * SHIFT_CLK_MAX_MHZ);
endpackage

// *** sbp_fifo_if.sv ***
// interface: valid/ready word stream between internal modules
`timescale 1ns/1ps
`default_nettype none
interface sbp_fifo_if #(parameter int W = 20);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** sbp_fifo.sv ***
// module: parameterised synchronous fifo with valid/ready
`timescale 1ns/1ps
`default_nettype none
module sbp_fifo #(
  parameter int W = 20,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // fill and drain sides
  sbp_fifo_if.snk wr,
  sbp_fifo_if.src rd,
  // status
  output logic full,
  output logic empty
);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wptr_q;
  logic [AW:0] rptr_q;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // flags from pointers; extra msb separates full from empty
  assign empty = (wptr_q == rptr_q);
  assign full = (wptr_q[AW] != rptr_q[AW]) &&
                (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem_q[rptr_q[AW-1:0]];
  assign push = wr.valid && !full;
  assign pop = rd.ready && !empty;

  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wptr_q[AW-1:0]] <= wr.data;
    end
  end

  // pointers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** sbp_side_band_port_assertions.sv ***
// checker: port-level timing relations of the side-band enable port
`timescale 1ns/1ps
`default_nettype none
module sbp_side_band_port_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // pins
  input wire logic out13_enable_or_load_pin,
  input wire logic [19:0] output_enable_pin_n,
  input wire logic serial_pattern_out,
  input wire logic [19:0] clk_out_enable,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  property p_rst_en;
    srst |=> clk_out_enable == 20'h0_0000;
  endproperty
  a_rst_en: assert property (p_rst_en)
    else $error("enables not cleared in reset");
  property p_rst_sout;
    srst |=> serial_pattern_out;
  endproperty
  a_rst_sout: assert property (p_rst_sout)
    else $error("serial out not high in reset");
  property p_rd_idle;
    disable iff (srst) !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside answer");
  property p_rd_upper;
    disable iff (srst) reg_rd |=> reg_rdata[31:20] == 12'h000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper bits set");
  property p_unmapped;
    disable iff (srst) reg_rd && reg_addr > 4'h5 |=> reg_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_mask_rb;
    disable iff (srst) reg_wr && reg_addr == 4'h1 ##1 reg_rd &&
      reg_addr == 4'h1 |=> reg_rdata[19:0] == $past(reg_wdata[19:0], 2);
  endproperty
  a_mask_rb: assert property (p_mask_rb)
    else $error("mask readback differs");
  // enable pin 4 held off for five cycles must have disabled output 4
  property p_pin_and;
    disable iff (srst) output_enable_pin_n[4] [*5] |-> !clk_out_enable[4];
  endproperty
  a_pin_and: assert property (p_pin_and)
    else $error("pin off but output enabled");
  property p_sout_hold;
    disable iff (srst) !out13_enable_or_load_pin [*6] |=>
      $stable(serial_pattern_out);
  endproperty
  a_sout_hold: assert property (p_sout_hold)
    else $error("serial out moved with strobe low");
endmodule
bind sbp_side_band_port sbp_side_band_port_assertions i_chk (
  .ref_clk(ref_clk), .srst(srst),
  .out13_enable_or_load_pin(out13_enable_or_load_pin),
  .output_enable_pin_n(output_enable_pin_n),
  .serial_pattern_out(serial_pattern_out), .clk_out_enable(clk_out_enable),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// *** sbp_ctrl_model.sv ***
// model: external controller that shifts enable patterns into the port
`timescale 1ns/1ps
`default_nettype none
module sbp_ctrl_model (
  // link pins toward the port
  output logic serial_pattern_in,
  output logic pattern_shift_clock,
  output logic out13_enable_or_load_pin
);
  initial begin
    serial_pattern_in = 1'b0;
    pattern_shift_clock = 1'b0;
    out13_enable_or_load_pin = 1'b0;
  end
  // full frame, msb first; odd offset keeps link edges off ref edges
  task automatic send(input logic [19:0] pat);
    // strobe high then 160 ns clocks
    #7 out13_enable_or_load_pin = 1'b1;
    #400;
    for (int i = 19; i >= 0; i--) begin
      serial_pattern_in = pat[i];
      #80 pattern_shift_clock = 1'b1;
      #80 pattern_shift_clock = 1'b0;
    end
    #200 out13_enable_or_load_pin = 1'b0;
    serial_pattern_in = ~pat[0];
  endtask
  task automatic wiggle();
    for (int i = 0; i < 20; i++) begin
      #87 serial_pattern_in = i[0];
      pattern_shift_clock = ~pattern_shift_clock;
    end
    pattern_shift_clock = 1'b0;
  endtask
  task automatic set_pin(input logic v);
    out13_enable_or_load_pin = v;
  endtask
endmodule
`default_nettype wire

// *** sbp_side_band_port_tb.sv ***
// testbench: scenario tasks for the side-band enable port
`timescale 1ns/1ps
`default_nettype none
module sbp_side_band_port_tb;
  logic ref_clk, srst, strap, pgood, wr, rd, sin, sclk, ld, sout;
  logic [19:0] pin_n, en;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  int n_fail, compares;
  localparam logic [19:0] PAT = 20'ha_5c3e;
  localparam logic [19:0] MSK = 20'h0_00f1;
  sbp_side_band_port i_dut (.ref_clk(ref_clk), .srst(srst),
    .side_port_strap(strap), .power_good(pgood), .serial_pattern_in(sin),
    .pattern_shift_clock(sclk), .out13_enable_or_load_pin(ld),
    .serial_pattern_out(sout), .output_enable_pin_n(pin_n),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .clk_out_enable(en));
  sbp_ctrl_model i_ctrl (.serial_pattern_in(sin),
    .pattern_shift_clock(sclk), .out13_enable_or_load_pin(ld));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk("reg_rdata", e, rdata);
  endtask
  task automatic wait_en(input logic [19:0] e);
    for (int i = 0; i < 300 && en !== e; i++) @(posedge ref_clk) #1;
    chk("clk_out_enable", {12'h000, e}, {12'h000, en});
    if (en !== e) finish_test();
  endtask
  task automatic t_reset(input logic s);
    strap <= s;
    srst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  // reset values of every register and an unmapped place
  task automatic t_defaults();
    wait_en(20'hf_ffff);
    rchk(4'h0, 32'h000f_ffff);
    rchk(4'h1, 32'h0000_0000);
    rchk(4'h2, 32'h000f_ffff);
    rchk(4'h3, 32'h000f_ffff);
    rchk(4'h4, 32'h0000_0009);
    rchk(4'h5, 32'h000f_ffff);
    rchk(4'hf, 32'h0000_0000);
  endtask
  task automatic t_shift();
    i_ctrl.send(PAT);
    wait_en(PAT);
    rchk(4'h2, {12'h000, PAT});
    rchk(4'h3, {12'h000, PAT});
    chk("serial_pattern_out", {31'h0, PAT[19]}, {31'h0, sout});
    i_ctrl.wiggle();
    repeat (8) @(posedge ref_clk);
    rchk(4'h2, {12'h000, PAT});
    chk("serial_pattern_out", {31'h0, PAT[19]}, {31'h0, sout});
  endtask
  // mask, gated bus enables, pins and the read-only shadow place
  task automatic t_mask();
    wreg(4'h1, {12'h000, MSK});
    rchk(4'h1, {12'h000, MSK});
    wait_en(PAT | MSK);
    wreg(4'h0, 32'h0000_0000);
    rchk(4'h0, 32'h000f_ffff);
    pgood <= 1'b1;
    wreg(4'h0, 32'h000f_fffb);
    wreg(4'h2, 32'h0000_0000);
    rchk(4'h2, {12'h000, PAT});
    rchk(4'h4, 32'h0000_000b);
    pin_n[4] <= 1'b1;
    wait_en((PAT | MSK) & 20'hf_ffeb);
  endtask
  task automatic t_strap_off();
    pgood <= 1'b0;
    pin_n <= 20'h0_0000;
    t_reset(1'b0);
    i_ctrl.send(20'h0_0000);
    repeat (10) @(posedge ref_clk);
    wait_en(20'hf_ffff);
    rchk(4'h4, 32'h0000_0008);
    chk("serial_pattern_out", 32'h0000_0000, {31'h0, sout});
    i_ctrl.set_pin(1'b1);
    wait_en(20'hf_dfff);
  endtask
  initial begin
    srst = 1'b1;
    strap = 1'b1;
    pgood = 1'b0;
    pin_n = 20'h0_0000;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    n_fail = 0;
    compares = 0;
    t_reset(1'b1);
    t_defaults();
    t_shift();
    t_mask();
    t_strap_off();
    finish_test();
  end
endmodule
`default_nettype wire
